// ===== logic/fcd_params.svh
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH
// ------------------------------------------------------------
// Opcodes and status codes
// ------------------------------------------------------------
`define FCD_OPC_COMMIT 8'h10
`define FCD_OPC_DOWNLOAD 8'h11
`define FCD_SCT_GENERIC 3'h0
`define FCD_SCT_CMD 3'h1
`define FCD_SC_OK 8'h00
`define FCD_SC_BAD_OPCODE 8'h01
`define FCD_SC_BAD_FIELD 8'h02
`define FCD_SC_INTERNAL 8'h06
`define FCD_SC_BAD_SLOT 8'h06
`define FCD_SC_BAD_IMAGE 8'h07
`define FCD_SC_NEED_CONV 8'h0B
`define FCD_SC_NEED_SUBSYS 8'h10
`define FCD_SC_NEED_RESET 8'h11
`define FCD_SC_MAX_TIME 8'h12
`define FCD_SC_PROHIBITED 8'h13
`define FCD_SC_OVERLAP 8'h14
// ------------------------------------------------------------
// Commit dword fields and actions
// ------------------------------------------------------------
`define FCD_CA_MSB 5
`define FCD_CA_LSB 3
`define FCD_FS_MSB 2
`define FCD_CA_REPLACE 3'h0
`define FCD_CA_REPLACE_ACT 3'h1
`define FCD_CA_ACT_NEXT 3'h2
`define FCD_CA_ACT_NOW 3'h3
`define FCD_SLOT_AUTO 3'h0
`define FCD_AUTO_SLOT 3'h1
`define FCD_PEND_NONE 2'h0
`define FCD_PEND_ANY 2'h1
`define FCD_PEND_CONV 2'h2
`define FCD_PEND_SUBSYS 2'h3
// ------------------------------------------------------------
// Staging image and range table
// ------------------------------------------------------------
`define FCD_IMG_DEPTH 64
`define FCD_IMG_WORDS 7'h40
`define FCD_IMG_LIMIT 32'h00000040
`define FCD_IDX_MSB 5
`define FCD_RANGES 8
`define FCD_RANGE_CNT_MAX 4'h8
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define FCD_REG_CFG 8'h00
`define FCD_REG_MAXACT 8'h04
`define FCD_REG_STATUS 8'h08
`define FCD_REG_LOADED 8'h0C
`define FCD_CFG_CNT_MSB 2
`define FCD_CFG_RO_MSB 15
`define FCD_CFG_RO_LSB 8
`define FCD_SLOT_CNT_RST 3'h7
`define FCD_RO_MASK_RST 8'h00
`define FCD_MAXACT_RST 16'h0064
`define FCD_LOADED_RST 8'h00
`define FCD_RUN_SLOT_RST 3'h1
`endif

// ===== logic/fcd_pkg.sv
package fcd_pkg;
  typedef struct packed {
    logic [15:0] cid;
    logic [7:0] opcode;
    logic [127:0] host_buffer_pointer;
    logic [31:0] cdw10;
    logic [31:0] cdw11;
  } fcd_cmd_type;
  typedef struct packed {
    logic [15:0] cid;
    logic [2:0] sct;
    logic [7:0] sc;
  } fcd_cpl_type;
  typedef struct packed {
    logic needs_conv;
    logic needs_subsys;
    logic no_immediate;
    logic prohibited;
    logic [15:0] act_time;
  } fcd_attr_type;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_FETCH = 5'b00010,
    S_EVAL = 5'b00100,
    S_STORE = 5'b01000,
    S_DONE = 5'b10000
  } fcd_state_type;
endpackage

// ===== logic/fcd_range_slot.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_range_slot (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic load,
  input wire logic [32:0] new_start,
  input wire logic [32:0] new_end,
  output logic hit
);
  logic valid_reg;
  logic [32:0] start_reg;
  logic [32:0] end_reg;
  // Inclusive ranges touch when neither lies wholly beside the other
  assign hit = valid_reg && !(new_end < start_reg) && !(new_start > end_reg);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      start_reg <= 33'h000000000;
      end_reg <= 33'h000000000;
    end else if (load) begin
      valid_reg <= 1'b1;
      start_reg <= new_start;
      end_reg <= new_end;
    end else if (clear) begin
      valid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== logic/fcd_nv_writer.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_nv_writer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [6:0] len,
  input wire logic nv_ack,
  input wire logic nv_fail,
  output logic nv_req,
  output logic [5:0] idx,
  output logic done,
  output logic fail
);
  logic busy_reg;
  logic [5:0] idx_reg;
  logic last;
  assign nv_req = busy_reg;
  assign idx = idx_reg;
  assign last = ({1'b0, idx_reg} == len - 7'h01);
  // Done and fail are one-cycle answers in the ack cycle
  assign done = busy_reg && nv_ack && !nv_fail && last;
  assign fail = busy_reg && nv_ack && nv_fail;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      idx_reg <= 6'h00;
    end else if (start) begin
      busy_reg <= 1'b1;
      idx_reg <= 6'h00;
    end else if (busy_reg && nv_ack) begin
      busy_reg <= !(nv_fail || last);
      idx_reg <= idx_reg + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ===== logic/fcd_top.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_params.svh"
module fcd_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CMD_VALID,
  input wire fcd_pkg::fcd_cmd_type CMD,
  output logic CMD_READY,
  output logic CPL_VALID,
  output fcd_pkg::fcd_cpl_type CPL,
  output logic FETCH_REQ,
  output logic [127:0] FETCH_PTR,
  output logic [31:0] FETCH_LEN,
  input wire logic DW_VALID,
  input wire logic [31:0] DW_DATA,
  input wire fcd_pkg::fcd_attr_type ATTR,
  output logic NV_REQ,
  output logic [2:0] NV_SLOT,
  output logic [5:0] NV_ADDR,
  output logic [31:0] NV_DATA,
  input wire logic NV_ACK,
  input wire logic NV_FAIL,
  input wire logic RST_CTRL,
  input wire logic RST_CONV,
  input wire logic RST_SUBSYS,
  output logic ACT_PULSE,
  output logic [2:0] RUN_SLOT,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);
  fcd_pkg::fcd_state_type state_reg, state_next;
  fcd_pkg::fcd_cmd_type cmd_reg;
  fcd_pkg::fcd_cpl_type cpl_reg, cpl_next;
  logic [31:0] stage_reg [`FCD_IMG_DEPTH];
  logic [32:0] cnt_reg;
  logic [3:0] range_cnt_reg;
  logic [6:0] len_reg;
  logic overlap_reg, have_zero_reg, fetch_req_reg, act_pulse_reg;
  logic [1:0] pend_kind_reg, pend_kind_next;
  logic [2:0] pend_slot_reg, run_slot_reg, slot_cnt_reg, run_slot_next;
  logic [7:0] ro_mask_reg, loaded_reg;
  logic [15:0] max_act_reg;
  logic [31:0] rdata_reg;

  // ------------------------------------------------------------
  // Command intake and download datapath
  // ------------------------------------------------------------
  wire accept = CMD_VALID && CMD_READY;
  wire [32:0] piece_dword_offset = {1'b0, cmd_reg.cdw11};
  wire [32:0] piece_dword_count = {1'b0, cmd_reg.cdw10};
  wire [32:0] piece_end = piece_dword_offset + piece_dword_count;
  wire [32:0] dw_pos = piece_dword_offset + cnt_reg;
  wire dw_in = (dw_pos < {1'b0, `FCD_IMG_LIMIT});
  wire [`FCD_IDX_MSB:0] dw_idx = dw_pos[`FCD_IDX_MSB:0];
  wire dw_last = DW_VALID && (cnt_reg == piece_dword_count);
  wire piece_done = (state_reg == fcd_pkg::S_FETCH) && dw_last;
  wire [6:0] end_len = (piece_end >= {1'b0, `FCD_IMG_LIMIT}) ? `FCD_IMG_WORDS :
                       (piece_end[6:0] + 7'h01);
  wire [`FCD_RANGES-1:0] hits;
  wire [`FCD_RANGES-1:0] loads;
  wire ranges_clear;
  genvar g;
  generate
    for (g = 0; g < `FCD_RANGES; g = g + 1) begin : g_range
      assign loads[g] = piece_done && (range_cnt_reg == 4'(g));
      fcd_range_slot u_slot (
        .clk(CLK),
        .rst_b(RST_B),
        .clear(ranges_clear),
        .load(loads[g]),
        .new_start(piece_dword_offset),
        .new_end(piece_end),
        .hit(hits[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Commit evaluation
  // ------------------------------------------------------------
  wire [2:0] ca = cmd_reg.cdw10[`FCD_CA_MSB:`FCD_CA_LSB];
  wire [2:0] fs = cmd_reg.cdw10[`FCD_FS_MSB:0];
  wire [2:0] slot = (fs == `FCD_SLOT_AUTO) ? `FCD_AUTO_SLOT : fs;
  wire ca_rsv = (ca > `FCD_CA_ACT_NOW);
  wire is_replace = (ca == `FCD_CA_REPLACE) || (ca == `FCD_CA_REPLACE_ACT);
  wire is_now = (ca == `FCD_CA_ACT_NOW);
  wire slot_bad = (slot > slot_cnt_reg) || ro_mask_reg[slot];
  wire img_ok = is_replace ? ((range_cnt_reg != 4'h0) && have_zero_reg) : loaded_reg[slot];
  wire too_slow = ATTR.act_time > max_act_reg;
  wire [7:0] reset_sc = ATTR.needs_subsys ? `FCD_SC_NEED_SUBSYS :
                        ATTR.needs_conv ? `FCD_SC_NEED_CONV : `FCD_SC_OK;
  wire [1:0] reset_kind = ATTR.needs_subsys ? `FCD_PEND_SUBSYS :
                          ATTR.needs_conv ? `FCD_PEND_CONV : `FCD_PEND_ANY;
  wire [7:0] ev_sc =
    slot_bad ? `FCD_SC_BAD_SLOT :
    (is_replace && overlap_reg) ? `FCD_SC_OVERLAP :
    !img_ok ? `FCD_SC_BAD_IMAGE :
    ((ca != `FCD_CA_REPLACE) && ATTR.prohibited) ? `FCD_SC_PROHIBITED :
    (is_now && ATTR.no_immediate) ? `FCD_SC_NEED_RESET :
    (is_now && too_slow) ? `FCD_SC_MAX_TIME :
    (is_now || (ca == `FCD_CA_REPLACE)) ? `FCD_SC_OK : reset_sc;
  wire ev_pass = !ca_rsv && ((ev_sc == `FCD_SC_OK) || (ev_sc == `FCD_SC_NEED_CONV) ||
                 (ev_sc == `FCD_SC_NEED_SUBSYS) || (ev_sc == `FCD_SC_NEED_RESET));
  wire in_eval = (state_reg == fcd_pkg::S_EVAL);
  wire ev_store = in_eval && ev_pass && is_replace;
  wire ev_act_now = in_eval && ev_pass && is_now && !ATTR.no_immediate;
  wire ev_pend = in_eval && ev_pass && ((ca == `FCD_CA_ACT_NEXT) || is_now);
  wire wr_done, wr_fail;
  wire st_done = (state_reg == fcd_pkg::S_STORE) && wr_done;
  wire st_fail = (state_reg == fcd_pkg::S_STORE) && wr_fail;
  wire st_pend = st_done && (ca == `FCD_CA_REPLACE_ACT);
  assign ranges_clear = st_done;

  fcd_nv_writer u_writer (
    .clk(CLK),
    .rst_b(RST_B),
    .start(ev_store),
    .len(len_reg),
    .nv_ack(NV_ACK),
    .nv_fail(NV_FAIL),
    .nv_req(NV_REQ),
    .idx(NV_ADDR),
    .done(wr_done),
    .fail(wr_fail)
  );
  assign NV_DATA = stage_reg[NV_ADDR];
  assign NV_SLOT = slot;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cpl_next = cpl_reg;
    unique case (state_reg)
      fcd_pkg::S_IDLE: begin
        if (accept) begin
          cpl_next = '{cid: CMD.cid, sct: `FCD_SCT_GENERIC, sc: `FCD_SC_OK};
          if (CMD.opcode == `FCD_OPC_DOWNLOAD) begin
            state_next = fcd_pkg::S_FETCH;
          end else if (CMD.opcode == `FCD_OPC_COMMIT) begin
            state_next = fcd_pkg::S_EVAL;
          end else begin
            cpl_next.sc = `FCD_SC_BAD_OPCODE;
            state_next = fcd_pkg::S_DONE;
          end
        end
      end
      fcd_pkg::S_FETCH: begin
        if (dw_last) begin
          state_next = fcd_pkg::S_DONE;
        end
      end
      fcd_pkg::S_EVAL: begin
        if (ca_rsv) begin
          cpl_next.sc = `FCD_SC_BAD_FIELD;
          state_next = fcd_pkg::S_DONE;
        end else begin
          cpl_next.sct = (ev_sc == `FCD_SC_OK) ? `FCD_SCT_GENERIC : `FCD_SCT_CMD;
          cpl_next.sc = ev_sc;
          state_next = ev_store ? fcd_pkg::S_STORE : fcd_pkg::S_DONE;
        end
      end
      fcd_pkg::S_STORE: begin
        // Hold the answer until storage truly ends
        if (wr_fail) begin
          cpl_next.sct = `FCD_SCT_GENERIC;
          cpl_next.sc = `FCD_SC_INTERNAL;
          state_next = fcd_pkg::S_DONE;
        end else if (wr_done) begin
          state_next = fcd_pkg::S_DONE;
        end
      end
      fcd_pkg::S_DONE: begin
        state_next = fcd_pkg::S_IDLE;
      end
    endcase
  end

  // Ready depends on nothing else outstanding in the system
  assign CMD_READY = (state_reg == fcd_pkg::S_IDLE);
  assign CPL_VALID = (state_reg == fcd_pkg::S_DONE);
  assign CPL = cpl_reg;
  assign FETCH_REQ = fetch_req_reg;
  assign ACT_PULSE = act_pulse_reg;
  assign RUN_SLOT = run_slot_reg;
  assign REG_RDATA = rdata_reg;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= fcd_pkg::S_IDLE;
      cpl_reg <= '0;
      cmd_reg <= '0;
      fetch_req_reg <= 1'b0;
      FETCH_PTR <= 128'h0;
      FETCH_LEN <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      cpl_reg <= cpl_next;
      fetch_req_reg <= accept && (CMD.opcode == `FCD_OPC_DOWNLOAD);
      if (accept) begin
        cmd_reg <= CMD;
      end
      if (accept && (CMD.opcode == `FCD_OPC_DOWNLOAD)) begin
        FETCH_PTR <= CMD.host_buffer_pointer;
        FETCH_LEN <= CMD.cdw10;
      end
    end
  end

  // Staging memory has no reset; valid ranges say what holds data
  always_ff @(posedge CLK) begin
    if ((state_reg == fcd_pkg::S_FETCH) && DW_VALID && dw_in) begin
      stage_reg[dw_idx] <= DW_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= 33'h000000000;
      range_cnt_reg <= 4'h0;
      len_reg <= 7'h00;
      overlap_reg <= 1'b0;
      have_zero_reg <= 1'b0;
    end else if (accept) begin
      cnt_reg <= 33'h000000000;
    end else if ((state_reg == fcd_pkg::S_FETCH) && DW_VALID) begin
      cnt_reg <= cnt_reg + 33'h000000001;
      if (dw_last) begin
        // Overlap is caught even though the host should never cause it
        overlap_reg <= overlap_reg || (|hits) ||
                       (range_cnt_reg == `FCD_RANGE_CNT_MAX);
        if (range_cnt_reg != `FCD_RANGE_CNT_MAX) begin
          range_cnt_reg <= range_cnt_reg + 4'h1;
        end
        if (end_len > len_reg) begin
          len_reg <= end_len;
        end
        have_zero_reg <= have_zero_reg || (piece_dword_offset == 33'h000000000);
      end
    end else if (st_done) begin
      range_cnt_reg <= 4'h0;
      len_reg <= 7'h00;
      overlap_reg <= 1'b0;
      have_zero_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Activation: pending image and reset events
  // ------------------------------------------------------------
  wire any_rst = RST_CTRL || RST_CONV || RST_SUBSYS;
  wire rst_act = ((pend_kind_reg == `FCD_PEND_ANY) && any_rst) ||
                 ((pend_kind_reg == `FCD_PEND_CONV) && (RST_CONV || RST_SUBSYS)) ||
                 ((pend_kind_reg == `FCD_PEND_SUBSYS) && RST_SUBSYS);
  wire [1:0] new_kind = (is_now && ATTR.no_immediate) ? `FCD_PEND_ANY : reset_kind;
  // A commit landing with a reset event wins the pending kind; the reset event still wins the run slot
  assign pend_kind_next = (ev_pend || st_pend) ? new_kind :
                          rst_act ? `FCD_PEND_NONE : pend_kind_reg;
  assign run_slot_next = rst_act ? pend_slot_reg : ev_act_now ? slot : run_slot_reg;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_kind_reg <= `FCD_PEND_NONE;
      pend_slot_reg <= `FCD_AUTO_SLOT;
      run_slot_reg <= `FCD_RUN_SLOT_RST;
      act_pulse_reg <= 1'b0;
    end else begin
      pend_kind_reg <= ev_act_now ? `FCD_PEND_NONE : pend_kind_next;
      if (ev_pend || st_pend) begin
        pend_slot_reg <= slot;
      end
      // Only commit paths and reset events reach here, never a download
      run_slot_reg <= run_slot_next;
      act_pulse_reg <= rst_act || ev_act_now;
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  wire [31:0] rd_mux =
    (REG_ADDR == `FCD_REG_CFG) ? {16'h0000, ro_mask_reg, 5'h00, slot_cnt_reg} :
    (REG_ADDR == `FCD_REG_MAXACT) ? {16'h0000, max_act_reg} :
    (REG_ADDR == `FCD_REG_STATUS) ? {7'h00, overlap_reg, range_cnt_reg,
                                     2'h0, pend_kind_reg, 1'b0, pend_slot_reg,
                                     1'b0, run_slot_reg, 3'h0, state_reg} :
    (REG_ADDR == `FCD_REG_LOADED) ? {24'h000000, loaded_reg} : 32'h00000000;
  wire [7:0] loaded_set = st_done ? (8'h01 << slot) : 8'h00;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slot_cnt_reg <= `FCD_SLOT_CNT_RST;
      ro_mask_reg <= `FCD_RO_MASK_RST;
      max_act_reg <= `FCD_MAXACT_RST;
      loaded_reg <= `FCD_LOADED_RST;
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= REG_RD ? rd_mux : 32'h00000000;
      if (REG_WR && (REG_ADDR == `FCD_REG_CFG)) begin
        slot_cnt_reg <= REG_WDATA[`FCD_CFG_CNT_MSB:0];
        ro_mask_reg <= REG_WDATA[`FCD_CFG_RO_MSB:`FCD_CFG_RO_LSB];
      end
      if (REG_WR && (REG_ADDR == `FCD_REG_MAXACT)) begin
        max_act_reg <= REG_WDATA[15:0];
      end
      // Hardware set wins over a software write in the same cycle
      loaded_reg <= ((REG_WR && (REG_ADDR == `FCD_REG_LOADED)) ? REG_WDATA[7:0] :
                     loaded_reg) | loaded_set;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_commit_waits;
    (state_reg == fcd_pkg::S_STORE) |=> (CPL_VALID == ($past(wr_done) || $past(wr_fail)));
  endproperty
  a_commit_waits: assert property (p_commit_waits) else $error("commit answered early");
  property p_act_any;
    (pend_kind_reg == `FCD_PEND_ANY && RST_CTRL && in_eval == 1'b0 && !st_pend)
      |=> (RUN_SLOT == $past(pend_slot_reg)) && ACT_PULSE;
  endproperty
  a_act_any: assert property (p_act_any) else $error("pending image not activated");
  property p_internal;
    st_fail |=> CPL_VALID && CPL.sct == `FCD_SCT_GENERIC && CPL.sc == `FCD_SC_INTERNAL;
  endproperty
  a_internal: assert property (p_internal) else $error("storage failure not reported");
  property p_bad_slot;
    (in_eval && !ca_rsv && slot_bad) |=> CPL_VALID && CPL.sc == `FCD_SC_BAD_SLOT ##1 CMD_READY;
  endproperty
  a_bad_slot: assert property (p_bad_slot) else $error("bad slot not refused");
  property p_conv_keep;
    (pend_kind_reg == `FCD_PEND_CONV && RST_CTRL && !RST_CONV && !RST_SUBSYS && !in_eval &&
     !st_pend) |=> $stable(RUN_SLOT) && pend_kind_reg == `FCD_PEND_CONV;
  endproperty
  a_conv_keep: assert property (p_conv_keep) else $error("light reset switched image");
  property p_subsys_keep;
    (pend_kind_reg == `FCD_PEND_SUBSYS && !RST_SUBSYS && !in_eval && !st_pend)
      |=> $stable(RUN_SLOT);
  endproperty
  a_subsys_keep: assert property (p_subsys_keep) else $error("image left early");
  property p_overlap;
    (in_eval && !ca_rsv && !slot_bad && is_replace && overlap_reg)
      |=> CPL_VALID && CPL.sc == `FCD_SC_OVERLAP;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap not reported");
  property p_place;
    (state_reg == fcd_pkg::S_FETCH && DW_VALID && dw_in)
      |=> stage_reg[$past(dw_idx)] == $past(DW_DATA);
  endproperty
  a_place: assert property (p_place) else $error("piece dword misplaced");
  property p_no_act_dl;
    (state_reg == fcd_pkg::S_FETCH && !rst_act) |=> !ACT_PULSE && $stable(RUN_SLOT);
  endproperty
  a_no_act_dl: assert property (p_no_act_dl) else $error("download activated an image");
  property p_dl_cpl;
    piece_done |=> CPL_VALID && CPL.sc == `FCD_SC_OK ##1 CMD_READY;
  endproperty
  a_dl_cpl: assert property (p_dl_cpl) else $error("download not completed");
  c_download: cover property (piece_done ##1 CPL_VALID);
  c_store_ok: cover property (st_done ##1 CPL_VALID);
  c_reset_act: cover property (rst_act ##1 ACT_PULSE);
endmodule
`default_nettype wire

// ===== sim/fcd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_host_model (
  input wire logic clk,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_len,
  input wire logic nv_req,
  input wire logic fail_en,
  output logic dw_valid,
  output logic [31:0] dw_data,
  output logic nv_ack,
  output logic nv_fail
);
  logic [31:0] left_reg = 32'h0;
  initial begin
    dw_valid = 1'b0;
    dw_data = 32'h5A5A0000;
    nv_ack = 1'b0;
  end
  // Idle data inverts each cycle so a stale word never passes as fresh
  always @(posedge clk) begin
    nv_ack <= nv_req && !nv_ack;
    dw_valid <= fetch_req || left_reg != 32'h0;
    dw_data <= dw_valid ? dw_data + 32'h1 : ~dw_data;
    if (fetch_req) begin
      left_reg <= fetch_len;
    end else if (left_reg != 32'h0) begin
      left_reg <= left_reg - 32'h1;
    end
  end
  assign nv_fail = nv_ack && fail_en;
endmodule
`default_nettype wire

// ===== sim/test_firmware_commit_download_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module test_firmware_commit_download_cmd;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CMD_VALID = 1'b0;
  fcd_pkg::fcd_cmd_type CMD = '0;
  fcd_pkg::fcd_attr_type ATTR = '0;
  fcd_pkg::fcd_cpl_type CPL;
  logic CMD_READY, CPL_VALID, FETCH_REQ, DW_VALID, NV_REQ, NV_ACK, NV_FAIL, ACT_PULSE;
  logic [127:0] FETCH_PTR;
  logic [31:0] FETCH_LEN, DW_DATA, NV_DATA, REG_RDATA;
  logic [2:0] NV_SLOT, RUN_SLOT;
  logic [5:0] NV_ADDR;
  logic RST_CTRL = 1'b0, RST_CONV = 1'b0, RST_SUBSYS = 1'b0;
  logic REG_WR = 1'b0, REG_RD = 1'b0, fail_en = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  int failures = 0, cmp_count = 0, cyc = 0;
  // Bench copy of the staging image, placed by piece offset
  logic [31:0] img [64];
  int wpos = 0;
  logic [2:0] exp_slot = 3'h0;
  always #20 CLK = ~CLK;
  fcd_top fcd_top_inst (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .CPL_VALID(CPL_VALID), .CPL(CPL), .FETCH_REQ(FETCH_REQ),
    .FETCH_PTR(FETCH_PTR), .FETCH_LEN(FETCH_LEN), .DW_VALID(DW_VALID), .DW_DATA(DW_DATA),
    .ATTR(ATTR), .NV_REQ(NV_REQ), .NV_SLOT(NV_SLOT), .NV_ADDR(NV_ADDR), .NV_DATA(NV_DATA),
    .NV_ACK(NV_ACK), .NV_FAIL(NV_FAIL), .RST_CTRL(RST_CTRL), .RST_CONV(RST_CONV),
    .RST_SUBSYS(RST_SUBSYS), .ACT_PULSE(ACT_PULSE), .RUN_SLOT(RUN_SLOT),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));
  fcd_host_model fcd_host_model_inst (.clk(CLK), .fetch_req(FETCH_REQ),
    .fetch_len(FETCH_LEN), .nv_req(NV_REQ), .fail_en(fail_en), .dw_valid(DW_VALID),
    .dw_data(DW_DATA), .nv_ack(NV_ACK), .nv_fail(NV_FAIL));
  task automatic report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Expected word is {sct, sc}
  always @(posedge CLK) begin
    if (DW_VALID === 1'b1) begin
      if (wpos < 64) img[wpos] <= DW_DATA;
      wpos <= wpos + 1;
    end
  end
  always @(negedge CLK) begin
    if (NV_REQ === 1'b1 && NV_ACK === 1'b1) begin
      chk(NV_DATA, img[NV_ADDR]);
      chk({29'h0, NV_SLOT}, {29'h0, exp_slot});
    end
  end
  task automatic run(input logic [7:0] op, input logic [31:0] c10, input logic [31:0] c11,
    input logic [31:0] exp);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD <= '{16'h0042, op, 128'h1000, c10, c11};
    @(negedge CLK);
    while (CMD_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    repeat (300) begin
      @(negedge CLK);
      if (CPL_VALID === 1'b1) break;
    end
    chk({31'h0, CPL_VALID}, 32'h1);
    chk({16'h0, CPL.cid}, 32'h0042);
    chk({21'h0, CPL.sct, CPL.sc}, exp);
    @(posedge CLK);
  endtask
  task automatic dl(input logic [31:0] off, input logic [31:0] n);
    wpos <= off;
    run(8'h11, n, off, 32'h0);
  endtask
  task automatic commit(input logic [2:0] ca, input logic [2:0] slot, input logic [31:0] exp);
    exp_slot <= slot;
    run(8'h10, {26'h0, ca, slot}, 32'h0, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    chk(REG_RDATA, exp);
  endtask
  task automatic rst_evt(input int k, input logic [2:0] exp, input logic act);
    @(posedge CLK);
    RST_CTRL <= k == 0;
    RST_CONV <= k == 1;
    RST_SUBSYS <= k == 2;
    @(posedge CLK);
    {RST_CTRL, RST_CONV, RST_SUBSYS} <= 3'b000;
    @(negedge CLK);
    chk({31'h0, ACT_PULSE}, {31'h0, act});
    @(negedge CLK);
    chk({29'h0, RUN_SLOT}, {29'h0, exp});
  endtask
  task automatic t_store;
    dl(32'h2, 32'h1);
    chk(FETCH_LEN, 32'h1);
    chk(FETCH_PTR[31:0], 32'h1000);
    dl(32'h0, 32'h1);
    chk({29'h0, RUN_SLOT}, 32'h1);
    commit(3'h0, 3'h2, 32'h0);
    chk({31'h0, NV_REQ}, 32'h0);
    rdchk(8'h0C, 32'h4);
  endtask
  task automatic t_bad;
    wr(8'h00, 32'h0404);
    rdchk(8'h00, 32'h0404);
    commit(3'h2, 3'h5, 32'h106);
    commit(3'h2, 3'h2, 32'h106);
    wr(8'h00, 32'h7);
    commit(3'h2, 3'h3, 32'h107);
    commit(3'h4, 3'h2, 32'h002);
    run(8'h55, 32'h0, 32'h0, 32'h001);
    rdchk(8'hF0, 32'h0);
  endtask
  task automatic t_attr;
    logic [19:0] at [3] = '{20'h10000, 20'h00065, 20'h20000};
    logic [2:0] ca [3] = '{3'h2, 3'h3, 3'h3};
    logic [31:0] ex [3] = '{32'h113, 32'h112, 32'h111};
    wr(8'h0C, 32'h0E);
    for (int i = 0; i < 3; i++) begin
      ATTR <= at[i];
      commit(ca[i], 3'h2, ex[i]);
    end
    ATTR <= '0;
    rst_evt(0, 3'h2, 1'b1);
  endtask
  task automatic t_pend;
    commit(3'h2, 3'h1, 32'h0);
    rst_evt(0, 3'h1, 1'b1);
    ATTR <= 20'h80000;
    commit(3'h2, 3'h3, 32'h10B);
    rst_evt(0, 3'h1, 1'b0);
    rst_evt(1, 3'h3, 1'b1);
    ATTR <= 20'h40000;
    commit(3'h2, 3'h2, 32'h110);
    rst_evt(1, 3'h3, 1'b0);
    rst_evt(2, 3'h2, 1'b1);
    ATTR <= '0;
    commit(3'h3, 3'h1, 32'h0);
    chk({29'h0, RUN_SLOT}, 32'h1);
  endtask
  task automatic t_fail;
    dl(32'h0, 32'h0);
    fail_en <= 1'b1;
    commit(3'h0, 3'h4, 32'h006);
    fail_en <= 1'b0;
    commit(3'h1, 3'h4, 32'h0);
    rst_evt(0, 3'h4, 1'b1);
    dl(32'h0, 32'h0);
    dl(32'h0, 32'h1);
    commit(3'h0, 3'h2, 32'h114);
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    t_store();
    t_bad();
    t_attr();
    t_pend();
    t_fail();
    report_and_stop();
  end
endmodule
`default_nettype wire
